// [acr_core.sv]
// converter primary control register, sequencer and dma address source
// assumes same-clock trigger pulses and a raw result from the analog core
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "acr_defs.svh"

module acr_core
    import acr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        cpu_idle_i,
    input  wire logic        ext_pin_i,
    input  wire logic        timer_match_i,
    input  wire logic        pwm_match_i,
    input  wire logic [11:0] raw_result_i,
    output logic             analog_on_o,
    output logic             sample_hold_o,
    output logic      [1:0]  channel_o,
    output logic             dma_req_o,
    output logic      [10:0] dma_addr_o,
    output logic      [15:0] dma_data_o,
    output logic             irq_o
);
    logic [15:0] ctrl, next_ctrl;
    logic [15:0] result, next_result;
    logic [2:0]  bufsize, next_bufsize;
    logic [1:0]  irq_stat, next_irq_stat;
    logic [1:0]  irq_en, next_irq_en;
    logic [15:0] rdata, next_rdata;
    acr_state_t  state, next_state;
    logic [7:0]  cnt, next_cnt;
    logic [1:0]  chan, next_chan;
    logic [6:0]  seq, next_seq;
    logic        dreq, next_dreq;
    logic [10:0] daddr, next_daddr;
    logic        irq, next_irq;
    logic [2:0]  pin_sync, next_pin_sync;
    logic        pin_prev, next_pin_prev;
    logic        pin_agree;
    logic        pin_edge;
    logic        next_analog_on;
    logic        next_sample_hold;
    logic [1:0]  next_channel;
    logic        running;
    logic        trig;
    logic [1:0]  last_chan;
    acr_fmt_if   fmt_bus ();

    // a write strobe aimed at the control word; software uses it to end a
    // manual sampling period, so it doubles as a trigger source
    function automatic logic hits_ctrl(input logic [3:0] a, input logic w);
        return w && (a == `ACR_ADDR_CTRL);
    endfunction

    // scatter/gather slot: the channel picks a block, the size its length;
    // offsets past the block end spill into the next channel's block
    function automatic logic [10:0] sg_addr(input logic [1:0] c,
                                            input logic [6:0] s,
                                            input logic [2:0] sz);
        logic [8:0] blk;
        blk = {c, 7'h00} >> (3'h7 - sz);
        return {2'h0, blk} + {6'h00, s[6:2]};
    endfunction

    acr_formatter u_fmt (
        .f (fmt_bus)
    );

    assign fmt_bus.raw   = raw_result_i;
    assign fmt_bus.res12 = ctrl[`ACR_BIT_RES];
    assign fmt_bus.fmt   = ctrl[`ACR_FORM_LO +: 2];

    // pin passes three flops; a change counts when stages two and three agree
    // so a level seen in only one of them never fires a trigger
    always_comb begin
        pin_agree     = (pin_sync[2] == pin_sync[1]);
        next_pin_sync = {pin_sync[1:0], ext_pin_i};
        next_pin_prev = pin_agree ? pin_sync[2] : pin_prev;
        pin_edge      = pin_agree && pin_sync[2] && !pin_prev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync <= 3'h0;
            pin_prev <= 1'b0;
        end else begin
            pin_sync <= next_pin_sync;
            pin_prev <= next_pin_prev;
        end
    end

    assign running = ctrl[`ACR_BIT_ON] && !(ctrl[`ACR_BIT_SIDL] && cpu_idle_i);
    assign last_chan = ctrl[`ACR_BIT_RES] ? 2'h0 : 2'h3;

    always_comb begin
        trig = 1'b0;
        unique case (ctrl[`ACR_SSRC_LO +: 3])
            ACR_SRC_AUTO:   trig = (cnt == 8'h00);
            ACR_SRC_PWM:    trig = pwm_match_i;
            ACR_SRC_TIMER:  trig = timer_match_i;
            ACR_SRC_EXTPIN: trig = pin_edge;
            ACR_SRC_MANUAL: trig = hits_ctrl(addr_i, wr_i)
                                   && !wdata_i[`ACR_BIT_SAMPLING_FLAG];
            default:        trig = 1'b0; // reserved codes never end sampling
        endcase
    end

    // read data stand for one cycle only and are zero otherwise
    always_comb begin
        next_rdata = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                `ACR_ADDR_CTRL:     next_rdata = ctrl;
                `ACR_ADDR_RESULT:   next_rdata = result;
                `ACR_ADDR_BUFSIZE:  next_rdata = {13'h0000, bufsize};
                `ACR_ADDR_DMAADDR:  next_rdata = {5'h00, daddr};
                `ACR_ADDR_IRQ_STAT: next_rdata = {14'h0000, irq_stat};
                `ACR_ADDR_IRQ_EN:   next_rdata = {14'h0000, irq_en};
                default:            next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    always_comb begin
        next_ctrl     = ctrl;
        next_result   = result;
        next_bufsize  = bufsize;
        next_irq_stat = irq_stat;
        next_irq_en   = irq_en;
        next_state    = state;
        next_cnt      = cnt;
        next_chan     = chan;
        next_seq      = seq;
        next_dreq     = 1'b0;
        next_daddr    = daddr;
        if (wr_i) begin
            unique case (addr_i)
                `ACR_ADDR_CTRL: begin
                    // a write can only clear done, never set it
                    next_ctrl = (wdata_i & `ACR_CTRL_WMASK)
                              | (ctrl & ~`ACR_CTRL_WMASK)
                              | 16'h0000;
                    next_ctrl[`ACR_BIT_DONE] = ctrl[`ACR_BIT_DONE]
                                             & wdata_i[`ACR_BIT_DONE];
                end
                `ACR_ADDR_BUFSIZE: next_bufsize = wdata_i[2:0];
                `ACR_ADDR_IRQ_EN:  next_irq_en = wdata_i[1:0];
                `ACR_ADDR_IRQ_CLR: next_irq_stat = irq_stat & ~wdata_i[1:0];
                default: ;
            endcase
        end
        unique case (state)
            ACR_ST_OFF: begin
                // sampling held low while off: software must turn the
                // module on first and then request sampling
                next_ctrl[`ACR_BIT_SAMPLING_FLAG] = 1'b0;
                next_chan = 2'h0;
                next_seq  = 7'h00;
                if (running) begin
                    next_state = ACR_ST_IDLE;
                end
            end
            ACR_ST_IDLE: begin
                if (!running) begin
                    next_state = ACR_ST_OFF;
                end else if (next_ctrl[`ACR_BIT_AUTOSAM]
                             || next_ctrl[`ACR_BIT_SAMPLING_FLAG]) begin
                    next_ctrl[`ACR_BIT_SAMPLING_FLAG] = 1'b1;
                    // with auto sample set this follows the last result at
                    // once, so done stands a single cycle in 12-bit mode but from channel 0's result on in 10-bit mode
                    next_ctrl[`ACR_BIT_DONE] = 1'b0;
                    next_cnt   = 8'(`ACR_SAMPLE_CYC);
                    next_state = ACR_ST_SAMPLE;
                end
            end
            ACR_ST_SAMPLE: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end
                if (!running) begin
                    next_state = ACR_ST_OFF;
                end else if (trig) begin
                    next_ctrl[`ACR_BIT_SAMPLING_FLAG] = 1'b0;
                    next_cnt   = 8'(`ACR_CONVERT_CYC);
                    next_state = ACR_ST_CONVERT;
                end
            end
            ACR_ST_CONVERT: begin
                if (!running) begin
                    next_state = ACR_ST_OFF;
                end else if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else begin
                    next_result = fmt_bus.word;
                    next_ctrl[`ACR_BIT_DONE] = 1'b1;
                    next_irq_stat[0] = 1'b1;
                    next_dreq = 1'b1;
                    if (ctrl[`ACR_BIT_BUILD]) begin
                        next_daddr = {4'h0, seq};
                    end else begin
                        next_daddr = sg_addr(chan, seq, bufsize);
                    end
                    next_seq = seq + 7'h01;
                    if (chan == last_chan) begin
                        next_chan = 2'h0;
                        next_irq_stat[1] = 1'b1;
                        next_state = ACR_ST_IDLE;
                    end else begin
                        next_chan  = chan + 2'h1;
                        next_cnt   = 8'(`ACR_CONVERT_CYC);
                    end
                end
            end
        endcase
        next_irq = |(next_irq_stat & next_irq_en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= `ACR_CTRL_RESET;
            result   <= 16'h0000;
            bufsize  <= `ACR_BUFSIZE_RESET;
            irq_stat <= 2'h0;
            irq_en   <= 2'h0;
            state    <= ACR_ST_OFF;
            cnt      <= 8'h00;
            chan     <= 2'h0;
            seq      <= 7'h00;
            dreq     <= 1'b0;
            daddr    <= 11'h000;
            irq      <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            result   <= next_result;
            bufsize  <= next_bufsize;
            irq_stat <= next_irq_stat;
            irq_en   <= next_irq_en;
            state    <= next_state;
            cnt      <= next_cnt;
            chan     <= next_chan;
            seq      <= next_seq;
            dreq     <= next_dreq;
            daddr    <= next_daddr;
            irq      <= next_irq;
        end
    end

    // analog outputs registered one cycle behind the sequencer
    always_comb begin
        next_analog_on   = running;
        next_sample_hold = ctrl[`ACR_BIT_SAMPLING_FLAG];
        next_channel     = chan;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_on_o   <= 1'b0;
            sample_hold_o <= 1'b0;
            channel_o     <= 2'h0;
        end else begin
            analog_on_o   <= next_analog_on;
            sample_hold_o <= next_sample_hold;
            channel_o     <= next_channel;
        end
    end

    assign rdata_o    = rdata;
    assign dma_req_o  = dreq;
    assign dma_addr_o = daddr;
    assign dma_data_o = result;
    assign irq_o      = irq;
endmodule

// [acr_core_assertions.sv]
// port checks for acr_core
// assumes one clock domain and a bind onto acr_core
`timescale 1ns/100ps
module acr_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic        cpu_idle_i,
    input wire logic [15:0] rdata_o,
    input wire logic        analog_on_o,
    input wire logic        dma_req_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic cw;
    assign cw = wr_i && addr_i == 4'h0;
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
        else $error("read data outside slot");
    a_unmapped_zero: assert property (rd_i && addr_i > 4'h6 |=>
        rdata_o == 16'h0) else $error("unmapped read not zero");
    a_on_start: assert property (cw && wdata_i[15] && !wdata_i[13]
        |-> ##[1:3] analog_on_o) else $error("module did not start");
    a_off_stop: assert property (cw && !wdata_i[15]
        |-> ##[1:3] !analog_on_o) else $error("module did not stop");
    a_idle_halt: assert property (cw && wdata_i[15] && wdata_i[13]
        && cpu_idle_i ##1 (cpu_idle_i && !wr_i) [*3] |-> !analog_on_o)
        else $error("idle did not halt");
    a_dma_gap: assert property (dma_req_o |=> !dma_req_o [*8])
        else $error("results too close");
    a_dma_when_off: assert property (!analog_on_o &&
        !$past(analog_on_o) |-> !dma_req_o) else $error("result while off");
    a_irq_cause: assert property ($rose(irq_o) |-> dma_req_o ||
        $past(wr_i)) else $error("irq without event");
    a_irq_clear: assert property (wr_i && addr_i == 4'h6 &&
        wdata_i[1:0] == 2'h3 && !dma_req_o ##1 !dma_req_o [*3] |-> !irq_o)
        else $error("irq not cleared");
    cover property (dma_req_o);
    cover property ($rose(irq_o));
    cover property (cw && wdata_i[13] && cpu_idle_i);
endmodule
bind acr_core acr_chk chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .cpu_idle_i(cpu_idle_i),
    .rdata_o(rdata_o), .analog_on_o(analog_on_o), .dma_req_o(dma_req_o),
    .irq_o(irq_o));

// [acr_core_tb.sv]
// bench for acr_core: registers, formats, triggers, idle stop
// assumes the design, its interface and the dma model compile first
`timescale 1ns/100ps
module acr_core_tb;
    `include "acr_defs.svh"
    logic        clk_i, rst_i, wr_i, rd_i, idle, pin, tmr, pwm;
    logic        on, sh, req, irq;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, dmad, dd, v, cv, ea;
    logic [11:0] raw;
    logic [10:0] dmaa, sa;
    logic [1:0]  ch;
    logic [7:0]  cnt, c0, q;
    logic [2:0]  src [5] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
    int          fail_count, checks;
    always #5 clk_i = ~clk_i;
    acr_core uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .cpu_idle_i(idle), .ext_pin_i(pin), .timer_match_i(tmr),
        .pwm_match_i(pwm), .raw_result_i(raw), .analog_on_o(on),
        .sample_hold_o(sh), .channel_o(ch), .dma_req_o(req),
        .dma_addr_o(dmaa), .dma_data_o(dmad), .irq_o(irq));
    acr_dma_sink dma (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .addr_i(dmaa), .data_i(dmad), .count_o(cnt), .addr_o(sa),
        .data_o(dd));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded: a missing result ends the run at once
    task automatic wait_dma(input logic [7:0] n);
        for (int i = 0; i < 200 && cnt !== n; i++) @(posedge clk_i);
        #1 chk("dma count", {8'h0, n}, {8'h0, cnt});
        if (cnt !== n) tally_and_finish();
    endtask
    function automatic logic [15:0] fmt(input logic r12,
        input logic [1:0] f, input logic [11:0] d);
        logic [15:0] u, m;
        int w;
        w = r12 ? 12 : 10;
        u = r12 ? {4'h0, d} : {6'h0, d[9:0]};
        m = 16'hFFFF << (w - 1);
        case (f)
            2'h0: return u;
            2'h1: return u[w-1] ? u & ~m : u | m;
            2'h2: return u << (16 - w);
            default: return {~u[w-1], 15'h0} | ((u & ~m) << (16 - w));
        endcase
    endfunction
    initial begin
        {clk_i, wr_i, rd_i, idle, pin, tmr, pwm} = '0;
        rst_i = 1'b1;
        addr = '0;
        wdata = '0;
        raw = 12'hA53;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, v);
        chk("ctrl reset", `ACR_CTRL_RESET, v);
        wr(4'h0, 16'h7FFC);
        rd(4'h0, v);
        chk("ctrl fields", 16'h37EC, v);
        rd(4'hF, v);
        chk("unmapped", 16'h0, v);
        wr(4'h3, 16'h0007);
        rd(4'h3, v);
        chk("buffer size", 16'h7, v);
        $display("test registers done");
        for (int k = 0; k < 8; k++) begin
            raw <= k[0] ? 12'hA53 : 12'h553;
            wr(4'h5, {14'h0, k[0], k[0]});
            c0 = cnt;
            cv = {1'b1, 2'h0, k[0], 1'b0, k[2], k[1:0], 8'h02};
            wr(4'h0, cv & 16'hFFFD);
            wr(4'h0, cv);
            rd(4'h0, v);
            chk("flags sampling", 16'h2, {14'h0, v[1:0]});
            chk("sample hold", 16'h1, {15'h0, sh});
            wr(4'h0, cv & 16'hFFFD);
            repeat (20) @(posedge clk_i);
            #1 chk("channel", {15'h0, !k[2]}, {14'h0, ch});
            wait_dma(c0 + (k[2] ? 8'h1 : 8'h4));
            chk("format", fmt(k[2], k[1:0], raw), dd);
            q = cnt - 8'h1;
            ea = k[0] ? {8'h0, q} : {7'h0, ~k[2], ~k[2], 7'h00} + (q >> 2);
            chk("dma addr", ea, {5'h0, sa});
            rd(4'h0, v);
            chk("flags done", 16'h1, {14'h0, v[1:0]});
            chk("sample hold off", 16'h0, {15'h0, sh});
            chk("irq level", {15'h0, k[0]}, {15'h0, irq});
            rd(4'h4, v);
            chk("status", 16'h3, v);
            wr(4'h6, 16'h3);
            rd(4'h4, v);
            chk("status clear", 16'h0, v);
            chk("irq clear", 16'h0, {15'h0, irq});
        end
        $display("test formats done");
        foreach (src[j]) begin
            wr(4'h0, 16'h0);
            c0 = cnt;
            wr(4'h0, 16'h8404 | {8'h0, src[j], 5'h0});
            repeat (25) @(posedge clk_i);
            chk("early end", {8'h0, c0}, {8'h0, cnt});
            tmr <= src[j] == 3'h2 || src[j] == 3'h4;
            pwm <= src[j] == 3'h3 || src[j] == 3'h4;
            pin <= src[j] == 3'h1 || src[j] == 3'h4;
            @(posedge clk_i);
            tmr <= 1'b0;
            pwm <= 1'b0;
            if (src[j] == 3'h4) begin
                repeat (60) @(posedge clk_i);
                chk("reserved", {8'h0, c0}, {8'h0, cnt});
            end else begin
                wait_dma(c0 + 8'h1);
            end
            pin <= 1'b0;
        end
        $display("test sources done");
        idle <= 1'b1;
        wr(4'h0, 16'hA000);
        repeat (4) @(posedge clk_i);
        chk("stop in idle", 16'h0, {15'h0, on});
        wr(4'h0, 16'h8000);
        repeat (4) @(posedge clk_i);
        chk("run in idle", 16'h1, {15'h0, on});
        idle <= 1'b0;
        wr(4'h0, 16'h0);
        repeat (4) @(posedge clk_i);
        chk("off", 16'h0, {15'h0, on});
        $display("test idle done");
        tally_and_finish();
    end
endmodule

// [acr_defs.svh]
// constants for the converter control register block
// assumes the includer sits inside a module or package scope
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_ADDR_CTRL      4'h0
`define ACR_ADDR_RESULT    4'h1
`define ACR_ADDR_DMAADDR   4'h2
`define ACR_ADDR_BUFSIZE   4'h3
`define ACR_ADDR_IRQ_STAT  4'h4
`define ACR_ADDR_IRQ_EN    4'h5
`define ACR_ADDR_IRQ_CLR   4'h6
`define ACR_CTRL_RESET     16'h0000
`define ACR_CTRL_WMASK     16'hB7EF
`define ACR_BIT_ON         15
`define ACR_BIT_SIDL       13
`define ACR_BIT_BUILD      12
`define ACR_BIT_RES        10
`define ACR_FORM_LO        8
`define ACR_SSRC_LO        5
`define ACR_BIT_SIMULTANEOUS_SAMPLING     3
`define ACR_BIT_AUTOSAM    2
`define ACR_BIT_SAMPLING_FLAG       1
`define ACR_BIT_DONE       0
`define ACR_SAMPLE_NS      200
`define ACR_CONVERT_NS     140
`define ACR_CLK_NS         10
`define ACR_SAMPLE_CYC     ((`ACR_SAMPLE_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_CONVERT_CYC    ((`ACR_CONVERT_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_BUFSIZE_RESET  3'h0
`endif

// [acr_dma_sink.sv]
// dma channel model: counts result transfers, keeps the last one
// assumes a one-cycle request with address and data beside it
`timescale 1ns/100ps
module acr_dma_sink (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [10:0] addr_i,
    input  wire logic [15:0] data_i,
    output logic      [7:0]  count_o,
    output logic      [10:0] addr_o,
    output logic      [15:0] data_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 8'h00;
        end else if (req_i) begin
            count_o <= count_o + 8'h01;
            addr_o <= addr_i;
            data_o <= data_i;
        end
    end
endmodule

// [acr_fmt_if.sv]
// carries a raw result to the formatter and the formatted word back
// assumes one clock domain; the formatter is purely combinational
`timescale 1ns/100ps
interface acr_fmt_if;
    logic [11:0] raw;
    logic        res12;
    logic [1:0]  fmt;
    logic [15:0] word;
    modport ctrl (output raw, output res12, output fmt, input word);
    modport conv (input raw, input res12, input fmt, output word);
endinterface

// [acr_formatter.sv]
// result formatter: unsigned, signed, fractional and signed fractional
// assumes raw data sits in the low bits; 10-bit results use raw[9:0]
`timescale 1ns/100ps
module acr_formatter
    import acr_pkg::*;
(
    acr_fmt_if.conv f
);
    logic [11:0] d;
    logic        s;
    always_comb begin
        d = f.res12 ? f.raw : {2'h0, f.raw[9:0]};
        s = f.res12 ? ~f.raw[11] : ~f.raw[9];
        f.word = 16'h0000;
        if (f.res12) begin
            unique case (acr_fmt_t'(f.fmt))
                ACR_FMT_SFRAC: f.word = {s, d[10:0], 4'h0};
                ACR_FMT_FRAC:  f.word = {d, 4'h0};
                ACR_FMT_SINT:  f.word = {{5{s}}, d[10:0]};
                ACR_FMT_UINT:  f.word = {4'h0, d};
            endcase
        end else begin
            unique case (acr_fmt_t'(f.fmt))
                ACR_FMT_SFRAC: f.word = {s, d[8:0], 6'h00};
                ACR_FMT_FRAC:  f.word = {d[9:0], 6'h00};
                ACR_FMT_SINT:  f.word = {{7{s}}, d[8:0]};
                ACR_FMT_UINT:  f.word = {6'h00, d[9:0]};
            endcase
        end
    end
endmodule

// [acr_pkg.sv]
// types shared by the converter control register block
// assumes acr_defs.svh sits in the same folder
package acr_pkg;
    typedef enum logic [2:0] {
        ACR_SRC_MANUAL = 3'h0,
        ACR_SRC_EXTPIN = 3'h1,
        ACR_SRC_TIMER  = 3'h2,
        ACR_SRC_PWM    = 3'h3,
        ACR_SRC_AUTO   = 3'h7
    } acr_src_t;
    typedef enum logic [1:0] {
        ACR_FMT_UINT  = 2'h0,
        ACR_FMT_SINT  = 2'h1,
        ACR_FMT_FRAC  = 2'h2,
        ACR_FMT_SFRAC = 2'h3
    } acr_fmt_t;
    typedef enum logic [1:0] {
        ACR_ST_OFF,
        ACR_ST_IDLE,
        ACR_ST_SAMPLE,
        ACR_ST_CONVERT
    } acr_state_t;
endpackage
